// file: logic/quad_wiper_serial_control.sv
// How it works
// - Write-protect low blocks nonvolatile setting updates
// - Serial input sampled on rising serial clock
// - Wiper position decoded to one-hot tap
// - Four independent wiper position registers
// - Write-wiper loads position from serial data
// - Copy command loads wiper from stored setting
// - Step command moves wiper one step per serial clock
// - Power-up loads wipers from slot zero
// - Four six-bit settings per pot, read/write
// - Copy either way between settings and wiper
// - Nonvolatile update completes within ten milliseconds
// - Save starts at select rise, complete only
// - Write-pending bit readable by status command
// - First byte after select falls is identification
// - Upper identification nibble must match type
// - Low identification bits must match straps
// - Instruction byte: opcode high, selects low
// - Serial output three-state when not driving
// - Read data shifted on falling serial clock
// - Select high: deselected, output high impedance
// - Pause input suspends without losing sequence
// - Instruction selects one setting and one pot, or all four pots for the global copy commands
`timescale 1ns/1ps
module quad_wiper_serial_control #(
    parameter int NV_WRITE_CYCLES = wiper_pkg::NV_WRITE_CYCLES
) (
    // System clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    sys_rst_in,
    // Serial link
    input  wire logic                    sck_in,
    input  wire logic                    cs_n_in,
    input  wire logic                    pause_n_in,
    input  wire logic                    si_in,
    output logic                         so_out,
    output logic                         so_oe_out,
    // Straps and protection
    input  wire logic                    wp_n_in,
    input  wire logic [1:0]              strap_address_pins_in,
    // Array taps and status
    output logic [3:0][63:0]             tap_sel_out,
    output logic                         nv_write_pending_out
);

    localparam int CNT_W = $clog2(NV_WRITE_CYCLES + 1);

    function automatic logic is_read(input logic [3:0] op);
        return (op == wiper_pkg::OP_RD_WIPER) || (op == wiper_pkg::OP_RD_SET) ||
               (op == wiper_pkg::OP_RD_STATUS);
    endfunction : is_read

    function automatic logic is_write3(input logic [3:0] op);
        return (op == wiper_pkg::OP_WR_WIPER) || (op == wiper_pkg::OP_WR_SET);
    endfunction : is_write3

    function automatic logic is_two(input logic [3:0] op);
        return (op == wiper_pkg::OP_XFR_TO_WIPER) || (op == wiper_pkg::OP_XFR_TO_SET) ||
               (op == wiper_pkg::OP_GXFR_TO_WIPER) || (op == wiper_pkg::OP_GXFR_TO_SET);
    endfunction : is_two

    function automatic logic [5:0] step_pos(input logic [5:0] pos, input logic up);
        if (up) begin
            return (pos == 6'h3f) ? pos : pos + 6'h01;
        end
        return (pos == 6'h00) ? pos : pos - 6'h01;
    endfunction : step_pos

    // ---------------- Link domain (serial clock) ----------------
    logic              frame_rst;
    logic [2:0]        bit_cnt_r;
    logic [1:0]        byte_idx_r;
    logic [7:0]        shift_r;
    logic              dead_r;
    logic              step_mode_r;
    logic              rd_active_r;
    wiper_pkg::cmd_s   lcmd_r;
    logic [5:0]        rd_hold_r;
    logic              so_r;
    logic              cmd_tog_r;
    logic              rd_tog_r;
    logic              up_tog_r;
    logic              dn_tog_r;
    logic [7:0]        byte_in;
    logic              byte_done;
    logic              id_ok;
    logic [3:0]        in_op;
    logic [7:0]        out_byte;

    // Clock-domain words read by the link side
    logic [1:0]        strap_sync_r;
    logic [5:0]        rd_word_r;

    assign frame_rst = cs_n_in | sys_rst_in;
    assign byte_in   = {shift_r[6:0], si_in};
    assign in_op     = byte_in[wiper_pkg::INS_OP_MSB:wiper_pkg::INS_OP_LSB];
    assign byte_done = (bit_cnt_r == wiper_pkg::BIT_LAST) && pause_n_in && !dead_r && !step_mode_r &&
                       (byte_idx_r != wiper_pkg::BYTE_DONE);
    assign id_ok     = (byte_in[wiper_pkg::ID_TYPE_MSB:wiper_pkg::ID_TYPE_LSB] == wiper_pkg::DEVICE_TYPE) &&
                       (byte_in[wiper_pkg::ID_ADR_MSB:wiper_pkg::ID_ADR_LSB] == strap_sync_r);
    assign out_byte  = {2'b00, rd_hold_r};

    // Frame sequencing; select high clears the whole frame
    always_ff @(posedge sck_in or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt_r   <= 3'h0;
            byte_idx_r  <= wiper_pkg::BYTE_ID;
            shift_r     <= 8'h00;
            dead_r      <= 1'b0;
            step_mode_r <= 1'b0;
            rd_active_r <= 1'b0;
            lcmd_r      <= '0;
            rd_hold_r   <= 6'h00;
        end else if (pause_n_in && !dead_r && !step_mode_r) begin
            if (byte_idx_r != wiper_pkg::BYTE_DONE) begin
                shift_r   <= byte_in;
                bit_cnt_r <= bit_cnt_r + 3'h1;
            end
            // Read word has settled long before its first live bit goes out
            if (rd_active_r && byte_idx_r == wiper_pkg::BYTE_DATA && bit_cnt_r == 3'h0) begin
                rd_hold_r <= rd_word_r;
            end
            if (byte_done) begin
                byte_idx_r <= byte_idx_r + 2'h1;
                case (byte_idx_r)
                    wiper_pkg::BYTE_ID: begin
                        if (!id_ok) begin
                            dead_r <= 1'b1;
                        end
                    end
                    wiper_pkg::BYTE_INSTR: begin
                        lcmd_r.op   <= in_op;
                        lcmd_r.slot <= byte_in[wiper_pkg::INS_SLOT_MSB:wiper_pkg::INS_SLOT_LSB];
                        lcmd_r.pot  <= byte_in[wiper_pkg::INS_POT_MSB:wiper_pkg::INS_POT_LSB];
                        step_mode_r <= (in_op == wiper_pkg::OP_STEP);
                        rd_active_r <= is_read(in_op);
                        if (!is_read(in_op) && !is_write3(in_op)) begin
                            byte_idx_r <= wiper_pkg::BYTE_DONE;
                        end
                    end
                    wiper_pkg::BYTE_DATA: begin
                        lcmd_r.data <= byte_in[5:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Event toggles toward the system clock; these survive select changes
    always_ff @(posedge sck_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cmd_tog_r <= 1'b0;
            rd_tog_r  <= 1'b0;
            up_tog_r  <= 1'b0;
            dn_tog_r  <= 1'b0;
        end else if (!cs_n_in && pause_n_in && !dead_r) begin
            if (byte_done && byte_idx_r == wiper_pkg::BYTE_INSTR && is_two(in_op)) begin
                cmd_tog_r <= ~cmd_tog_r;
            end
            if (byte_done && byte_idx_r == wiper_pkg::BYTE_INSTR && is_read(in_op)) begin
                rd_tog_r <= ~rd_tog_r;
            end
            // Only a full data byte completes a write sequence
            if (byte_done && byte_idx_r == wiper_pkg::BYTE_DATA && is_write3(lcmd_r.op)) begin
                cmd_tog_r <= ~cmd_tog_r;
            end
            if (step_mode_r) begin
                if (si_in) begin
                    up_tog_r <= ~up_tog_r;
                end else begin
                    dn_tog_r <= ~dn_tog_r;
                end
            end
        end
    end

    // Read data leaves on the falling edge, most significant bit first
    always_ff @(negedge sck_in or posedge frame_rst) begin
        if (frame_rst) begin
            so_r <= 1'b0;
        end else if (pause_n_in) begin
            so_r <= out_byte[~bit_cnt_r];
        end
    end

    assign so_out    = so_r;
    assign so_oe_out = rd_active_r && (byte_idx_r == wiper_pkg::BYTE_DATA) &&
                       !cs_n_in && pause_n_in && !dead_r;

    // ---------------- System clock domain ----------------
    logic                    cs_meta_r;
    logic                    cs_sync_r;
    logic                    wp_meta_r;
    logic                    wp_sync_r;
    logic [1:0]              strap_meta_r;
    logic [3:0]              tog_meta_r;
    logic [3:0]              tog_sync_r;
    logic [3:0]              tog_prev_r;
    logic [3:0]              tog_ev;
    wiper_pkg::ctl_state_e   state_r;
    logic [1:0]              idx_r;
    logic [1:0]              last_r;
    logic [1:0]              slot_r;
    logic [CNT_W-1:0]        cnt_r;
    logic                    wip_r;
    logic                    cmd_pend_r;
    wiper_pkg::cmd_s         pend_cmd_r;
    logic                    nv_pend_r;
    wiper_pkg::cmd_s         nv_cmd_r;
    logic                    rd_pend_r;
    wiper_pkg::cmd_s         rd_cmd_r;
    logic                    rd_cap_r;
    logic                    ld_valid_r;
    logic [1:0]              ld_pot_r;
    logic [3:0][5:0]         wiper_r;
    logic [3:0][63:0]        tap_sel_r;
    logic                    commit_go;
    logic                    cmd_take;
    logic                    rd_go;
    logic [3:0]              rd_addr;
    logic [5:0]              mem_rd;
    logic                    mem_wr;
    logic [5:0]              mem_wr_data;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cs_meta_r    <= 1'b1;
            cs_sync_r    <= 1'b1;
            wp_meta_r    <= 1'b0;
            wp_sync_r    <= 1'b0;
            strap_meta_r <= 2'h0;
            strap_sync_r <= 2'h0;
            tog_meta_r   <= 4'h0;
            tog_sync_r   <= 4'h0;
            tog_prev_r   <= 4'h0;
        end else begin
            cs_meta_r    <= cs_n_in;
            cs_sync_r    <= cs_meta_r;
            wp_meta_r    <= wp_n_in;
            wp_sync_r    <= wp_meta_r;
            strap_meta_r <= strap_address_pins_in;
            strap_sync_r <= strap_meta_r;
            tog_meta_r   <= {dn_tog_r, up_tog_r, rd_tog_r, cmd_tog_r};
            tog_sync_r   <= tog_meta_r;
            tog_prev_r   <= tog_sync_r;
        end
    end

    assign tog_ev    = tog_sync_r ^ tog_prev_r;
    assign commit_go = (state_r == wiper_pkg::ST_IDLE) && nv_pend_r && cs_sync_r;
    assign cmd_take  = (state_r == wiper_pkg::ST_IDLE) && cmd_pend_r && !commit_go;
    assign rd_go     = rd_pend_r && (state_r != wiper_pkg::ST_RECALL);
    assign rd_addr   = (state_r == wiper_pkg::ST_RECALL) ? wiper_pkg::set_addr(idx_r, slot_r) :
                       wiper_pkg::set_addr(rd_cmd_r.pot, rd_cmd_r.slot);
    assign mem_wr    = (state_r == wiper_pkg::ST_STORE);
    assign mem_wr_data = (nv_cmd_r.op == wiper_pkg::OP_WR_SET) ? nv_cmd_r.data : wiper_r[idx_r];

    // Control sequencer: recall, commit and nonvolatile timing
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r    <= wiper_pkg::ST_RECALL;
            idx_r      <= 2'h0;
            last_r     <= 2'h3;
            slot_r     <= wiper_pkg::RECALL_SLOT;
            cnt_r      <= '0;
            wip_r      <= 1'b0;
            cmd_pend_r <= 1'b0;
            pend_cmd_r <= '0;
            nv_pend_r  <= 1'b0;
            nv_cmd_r   <= '0;
        end else begin
            if (cmd_take) begin
                cmd_pend_r <= 1'b0;
            end
            if (tog_ev[0]) begin
                cmd_pend_r <= 1'b1;
                pend_cmd_r <= lcmd_r;
            end
            case (state_r)
                wiper_pkg::ST_RECALL: begin
                    idx_r <= idx_r + 2'h1;
                    if (idx_r == last_r) begin
                        state_r <= wiper_pkg::ST_IDLE;
                    end
                end
                wiper_pkg::ST_IDLE: begin
                    if (commit_go) begin
                        nv_pend_r <= 1'b0;
                        if (wp_sync_r) begin
                            state_r <= wiper_pkg::ST_STORE;
                            wip_r   <= 1'b1;
                            cnt_r   <= '0;
                            slot_r  <= nv_cmd_r.slot;
                            idx_r   <= (nv_cmd_r.op == wiper_pkg::OP_GXFR_TO_SET) ? 2'h0 : nv_cmd_r.pot;
                            last_r  <= (nv_cmd_r.op == wiper_pkg::OP_GXFR_TO_SET) ? 2'h3 : nv_cmd_r.pot;
                        end
                    end else if (cmd_take) begin
                        case (pend_cmd_r.op)
                            wiper_pkg::OP_XFR_TO_WIPER: begin
                                state_r <= wiper_pkg::ST_RECALL;
                                slot_r  <= pend_cmd_r.slot;
                                idx_r   <= pend_cmd_r.pot;
                                last_r  <= pend_cmd_r.pot;
                            end
                            wiper_pkg::OP_GXFR_TO_WIPER: begin
                                state_r <= wiper_pkg::ST_RECALL;
                                slot_r  <= pend_cmd_r.slot;
                                idx_r   <= 2'h0;
                                last_r  <= 2'h3;
                            end
                            wiper_pkg::OP_WR_SET,
                            wiper_pkg::OP_XFR_TO_SET,
                            wiper_pkg::OP_GXFR_TO_SET: begin
                                nv_pend_r <= 1'b1;
                                nv_cmd_r  <= pend_cmd_r;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                // Store cycles count toward the write time so pending never outlasts it
                wiper_pkg::ST_STORE: begin
                    idx_r <= idx_r + 2'h1;
                    cnt_r <= cnt_r + CNT_W'(1);
                    if (idx_r == last_r) begin
                        state_r <= wiper_pkg::ST_NV_WAIT;
                    end
                end
                wiper_pkg::ST_NV_WAIT: begin
                    cnt_r <= cnt_r + CNT_W'(1);
                    if (cnt_r >= CNT_W'(NV_WRITE_CYCLES - 1)) begin
                        state_r <= wiper_pkg::ST_IDLE;
                        wip_r   <= 1'b0;
                    end
                end
                default: begin
                    state_r <= wiper_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Read requests; answer word for the link side
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_pend_r <= 1'b0;
            rd_cmd_r  <= '0;
            rd_cap_r  <= 1'b0;
            rd_word_r <= 6'h00;
        end else begin
            rd_cap_r <= rd_go && (rd_cmd_r.op == wiper_pkg::OP_RD_SET);
            if (rd_go) begin
                rd_pend_r <= 1'b0;
            end
            if (tog_ev[1]) begin
                rd_pend_r <= 1'b1;
                rd_cmd_r  <= lcmd_r;
            end
            if (rd_cap_r) begin
                rd_word_r <= mem_rd;
            end else if (rd_go && rd_cmd_r.op == wiper_pkg::OP_RD_WIPER) begin
                rd_word_r <= wiper_r[rd_cmd_r.pot];
            end else if (rd_go && rd_cmd_r.op == wiper_pkg::OP_RD_STATUS) begin
                rd_word_r <= 6'h00;
                rd_word_r[wiper_pkg::STATUS_WIP_BIT] <= wip_r;
            end
        end
    end

    // Wiper position registers
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ld_valid_r <= 1'b0;
            ld_pot_r   <= 2'h0;
            wiper_r    <= {wiper_pkg::POTS{wiper_pkg::WIPER_RST}};
        end else begin
            ld_valid_r <= (state_r == wiper_pkg::ST_RECALL);
            ld_pot_r   <= idx_r;
            if (ld_valid_r) begin
                wiper_r[ld_pot_r] <= mem_rd;
            end else if (cmd_take && pend_cmd_r.op == wiper_pkg::OP_WR_WIPER) begin
                wiper_r[pend_cmd_r.pot] <= pend_cmd_r.data;
            end else if (tog_ev[2] != tog_ev[3]) begin
                wiper_r[lcmd_r.pot] <= step_pos(wiper_r[lcmd_r.pot], tog_ev[2]);
            end
        end
    end

    // One-hot tap selection per array
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tap_sel_r <= '0;
        end else begin
            for (int i = 0; i < wiper_pkg::POTS; i++) begin
                tap_sel_r[i] <= 64'h1 << wiper_r[i];
            end
        end
    end

    assign tap_sel_out          = tap_sel_r;
    assign nv_write_pending_out = wip_r;

    setting_store #(
        .DATA_W (wiper_pkg::POS_W),
        .ADDR_W (wiper_pkg::SET_ADR_W),
        .INIT   (wiper_pkg::SETTING_INIT)
    ) u_store (
        .clk_in      (clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (mem_wr),
        .wr_addr_in  (wiper_pkg::set_addr(idx_r, slot_r)),
        .wr_data_in  (mem_wr_data),
        .rd_addr_in  (rd_addr),
        .rd_data_out (mem_rd)
    );

endmodule : quad_wiper_serial_control

// file: logic/setting_store.sv
`timescale 1ns/1ps
module setting_store #(
    parameter int         DATA_W = 6,
    parameter int         ADDR_W = 4,
    parameter logic [5:0] INIT   = 6'h00
) (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              sys_rst_in,
    // Write port
    input  wire logic              wr_en_in,
    input  wire logic [ADDR_W-1:0] wr_addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    // Read port, one cycle latency
    input  wire logic [ADDR_W-1:0] rd_addr_in,
    output logic      [DATA_W-1:0] rd_data_out
);

    logic [DATA_W-1:0] mem_r [2**ADDR_W];

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < 2**ADDR_W; i++) begin
                mem_r[i] <= DATA_W'(INIT);
            end
        end else if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= mem_r[rd_addr_in];
        end
    end

endmodule : setting_store

// file: logic/wiper_pkg.sv
package wiper_pkg;

    // Array geometry
    localparam int POTS      = 4;
    localparam int SLOTS     = 4;
    localparam int POS_W     = 6;
    localparam int TAPS      = 64;
    localparam int SET_ADR_W = 4;

    // Device type code carried in the identification byte; value is arbitrary
    localparam logic [3:0] DEVICE_TYPE = 4'h3;

    // Identification byte fields
    localparam int ID_TYPE_MSB = 7;
    localparam int ID_TYPE_LSB = 4;
    localparam int ID_ADR_MSB  = 1;
    localparam int ID_ADR_LSB  = 0;

    // Instruction byte fields
    localparam int INS_OP_MSB   = 7;
    localparam int INS_OP_LSB   = 4;
    localparam int INS_SLOT_MSB = 3;
    localparam int INS_SLOT_LSB = 2;
    localparam int INS_POT_MSB  = 1;
    localparam int INS_POT_LSB  = 0;

    // Opcodes
    localparam logic [3:0] OP_RD_WIPER       = 4'h9;
    localparam logic [3:0] OP_WR_WIPER       = 4'ha;
    localparam logic [3:0] OP_RD_SET         = 4'hb;
    localparam logic [3:0] OP_WR_SET         = 4'hc;
    localparam logic [3:0] OP_XFR_TO_WIPER   = 4'hd;
    localparam logic [3:0] OP_XFR_TO_SET     = 4'he;
    localparam logic [3:0] OP_GXFR_TO_WIPER  = 4'h1;
    localparam logic [3:0] OP_GXFR_TO_SET    = 4'h8;
    localparam logic [3:0] OP_STEP           = 4'h2;
    localparam logic [3:0] OP_RD_STATUS      = 4'h5;

    // Byte positions within a frame
    localparam logic [1:0] BYTE_ID    = 2'h0;
    localparam logic [1:0] BYTE_INSTR = 2'h1;
    localparam logic [1:0] BYTE_DATA  = 2'h2;
    localparam logic [1:0] BYTE_DONE  = 2'h3;
    localparam logic [2:0] BIT_LAST   = 3'h7;

    // Reset values and status layout
    localparam logic [5:0] WIPER_RST     = 6'h00;
    localparam logic [5:0] SETTING_INIT  = 6'h00;
    localparam logic [1:0] RECALL_SLOT   = 2'h0;
    localparam int         STATUS_WIP_BIT = 0;

    // Nonvolatile write time
    localparam int CLK_PERIOD_NS    = 8;
    localparam int NV_WRITE_TIME_MS = 10;
    localparam int NV_WRITE_CYCLES  = NV_WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;

    typedef struct packed {
        logic [3:0] op;
        logic [1:0] slot;
        logic [1:0] pot;
        logic [5:0] data;
    } cmd_s;

    typedef enum logic [1:0] {
        ST_RECALL,
        ST_IDLE,
        ST_STORE,
        ST_NV_WAIT
    } ctl_state_e;

    function automatic logic [SET_ADR_W-1:0] set_addr(input logic [1:0] pot, input logic [1:0] slot);
        return {pot, slot};
    endfunction : set_addr

endpackage : wiper_pkg

// file: tb/quad_wiper_serial_control_assertions.sv
`timescale 1ns/1ps
module quad_wiper_serial_control_assertions #(
    parameter int NV_WRITE_CYCLES = 20
) (
    // Watched ports
    input wire logic             clk_in, sys_rst_in, sck_in, cs_n_in, pause_n_in, wp_n_in,
    input wire logic             so_out, so_oe_out, nv_write_pending_out,
    input wire logic [3:0][63:0] tap_sel_out
);
    logic [31:0] pend_cnt_r;
    logic [3:0]  onehot_r;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    always_ff @(posedge clk_in or posedge sys_rst_in)
        if (sys_rst_in) pend_cnt_r <= '0;
        else pend_cnt_r <= nv_write_pending_out ? pend_cnt_r + 32'h1 : '0;
    always_comb
        for (int p = 0; p < 4; p++) onehot_r[p] = $onehot(tap_sel_out[p]);
    sel_oe_a: assert property (cs_n_in |-> !so_oe_out) else $error("output enabled while deselected");
    pause_oe_a: assert property (!pause_n_in |-> !so_oe_out) else $error("output enabled in pause");
    tap_onehot_a: assert property (!$past(sys_rst_in, 12) |-> &onehot_r) else $error("tap not one-hot");
    pend_max_a: assert property (pend_cnt_r <= NV_WRITE_CYCLES) else $error("write too long");
    pend_min_a: assert property ($fell(nv_write_pending_out) |-> pend_cnt_r + 1 >= NV_WRITE_CYCLES)
        else $error("write too short");
    pend_cs_a: assert property ($rose(nv_write_pending_out) |-> cs_n_in && $past(cs_n_in))
        else $error("save while selected");
    pend_wp_a: assert property ($rose(nv_write_pending_out) |-> $past(wp_n_in, 3)) else $error("save when protected");
    so_shift_a: assert property (so_oe_out && sck_in && $past(sck_in) |-> $stable(so_out))
        else $error("output moved with clock high");
endmodule : quad_wiper_serial_control_assertions

bind quad_wiper_serial_control quad_wiper_serial_control_assertions #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) checker_i (
    .clk_in, .sys_rst_in, .sck_in, .cs_n_in, .pause_n_in, .wp_n_in, .so_out, .so_oe_out, .nv_write_pending_out,
    .tap_sel_out);

// file: tb/quad_wiper_serial_control_tb.sv
`timescale 1ns/1ps
module quad_wiper_serial_control_tb;
    localparam int NV = 600;
    localparam logic [7:0] ID = {wiper_pkg::DEVICE_TYPE, 4'h2};
    logic             clk_in, sys_rst_in, sck, cs_n, pause_n, si, so_out, so_oe_out, wp_n_in, pend;
    logic [1:0]       strap_r;
    logic [3:0][63:0] tap_sel_out;
    logic [7:0]       bad [2] = '{8'h31, 8'h72};
    int               n_fail, tests_run, cyc;
    initial {clk_in, sys_rst_in, wp_n_in, strap_r, n_fail, tests_run, cyc} = {5'h0e, 96'h0};
    always #4 clk_in = ~clk_in;
    quad_wiper_serial_control #(.NV_WRITE_CYCLES(NV)) quad_wiper_serial_control_i (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sck_in(sck), .cs_n_in(cs_n), .pause_n_in(pause_n),
        .si_in(si), .so_out(so_out), .so_oe_out(so_oe_out), .wp_n_in(wp_n_in), .strap_address_pins_in(strap_r),
        .tap_sel_out(tap_sel_out), .nv_write_pending_out(pend));
    wiper_host wiper_host_i (.sck_out(sck), .cs_n_out(cs_n), .pause_n_out(pause_n), .si_out(si),
        .so_in(so_out), .so_oe_in(so_oe_out));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cmd(input logic [7:0] ins, input logic [7:0] d, input int n);
        wiper_host_i.xfer({ID, ins, d}, n);
    endtask : cmd
    task automatic wait_idle();
        for (int i = 0; i < 2000 && pend !== 1'b0; i++) @(posedge clk_in);
        check(pend, 1'b0);
    endtask : wait_idle
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        for (int p = 0; p < 4; p++) check(tap_sel_out[p], 64'h1);
        cmd(8'ha1, 8'h3d, 24);
        check(tap_sel_out[1], 64'h1 << 61);
        cmd(8'h91, 8'h00, 24);
        check(wiper_host_i.rd_r, 8'h3d);
        foreach (bad[k]) begin
            wiper_host_i.xfer({bad[k], 8'ha1, 8'h05}, 24);
            wiper_host_i.xfer({bad[k], 8'h91, 8'h00}, 24);
            check(wiper_host_i.rd_r, 8'hff);
        end
        check(tap_sel_out[1], 64'h1 << 61);
        cmd(8'h21, 8'h80, 17);
        check(tap_sel_out[1], 64'h1 << 62);
        cmd(8'h21, 8'hff, 24);
        check(tap_sel_out[1], 64'h1 << 63);
        cmd(8'h20, 8'h00, 24);
        check(tap_sel_out[0], 64'h1);
        cmd(8'hce, 8'h15, 24);
        cmd(8'h51, 8'h00, 24);
        check(wiper_host_i.rd_r, 8'h01);
        wait_idle();
        @(posedge clk_in) wp_n_in <= 1'b0;
        cmd(8'hce, 8'h07, 24);
        check(pend, 1'b0);
        @(posedge clk_in) wp_n_in <= 1'b1;
        wiper_host_i.xfer({ID, 8'hce, 8'h09}, 20);
        check(pend, 1'b0);
        cmd(8'hbe, 8'h00, 24);
        check(wiper_host_i.rd_r, 8'h15);
        cmd(8'hde, 8'h00, 16);
        check(tap_sel_out[2], 64'h1 << 21);
        cmd(8'he2, 8'h00, 16);
        wait_idle();
        cmd(8'h10, 8'h00, 16);
        check(tap_sel_out[1], 64'h1);
        check(tap_sel_out[2], 64'h1 << 21);
        summarize();
    end
endmodule : quad_wiper_serial_control_tb

// file: tb/wiper_host.sv
`timescale 1ns/1ps
module wiper_host (
    // Serial link towards the device
    output logic      sck_out,
    output logic      cs_n_out,
    output logic      pause_n_out,
    output logic      si_out,
    input  wire logic so_in,
    input  wire logic so_oe_in
);
    logic [7:0] rd_r;
    initial begin
        {sck_out, cs_n_out, pause_n_out, si_out, rd_r} = {4'h6, 8'h00};
    end
    // Clock idles low outside frames; an undriven output reads as pulled high
    task automatic xfer(input logic [23:0] w, input int n);
        // Keep link edges clear of system clock edges
        #2;
        cs_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            si_out = w[23-i];
            #40 rd_r = {rd_r[6:0], so_oe_in ? so_in : 1'b1};
            if (i == 12) begin
                pause_n_out = 1'b0;
                #160 pause_n_out = 1'b1;
                #40;
            end
            sck_out = 1'b1;
            #40 sck_out = 1'b0;
        end
        #40 cs_n_out = 1'b1;
        si_out = ~si_out;
        #398;
    endtask : xfer
endmodule : wiper_host
